// ===== psc_board.sv
`timescale 1ns/1ps
`default_nettype none
module psc_board #(parameter N = 4) (
   input  wire          ref_clk_i, // Clock
   input  wire [N-1:0]  drv_i,     // Pad output levels
   input  wire [N-1:0]  oe_n_i,    // Pad enables, low drives
   output logic [N-1:0] lvl_o,     // Wire levels seen by the pads
   output logic         xtal_o     // Crystal waveform
);
   // A released pad has no pull, so it shows the inverse of its last
   // level; a stale value can then never pass for a driven one.
   initial begin
      lvl_o = '0;
      xtal_o = 1'b0;
   end
   always @(negedge ref_clk_i) begin
      lvl_o <= (drv_i & ~oe_n_i) | (~lvl_o & oe_n_i);
      xtal_o <= ~xtal_o;
   end
endmodule // psc_board
`default_nettype wire

// ===== psc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module psc_chk #(parameter N = 16) (
   input wire         ref_clk_i,               // Clock
   input wire         sys_rst_i,               // Sync reset
   input wire [2:0]   dev_state_i,             // Device state
   input wire [1:0]   standby_mode_i,          // Standby kind
   input wire         ext_reset_in_low_i,      // External reset held
   input wire         standby_pin_level_sel_i, // Standby select
   input wire [2*N-1:0] pin_func_i,            // Functions
   input wire [N-1:0] pad_out_o,               // Pad levels
   input wire [N-1:0] pad_oe_n_o,              // Pad enables
   input wire [N-1:0] core_in_o,               // Internal inputs
   input wire [N-1:0] analog_en_o,             // Analog paths
   input wire         xtal_main_in_en_o,       // Main osc input on
   input wire         xtal_sub_in_en_o,        // Sub osc input on
   input wire         osc_main_oe_n_o,         // Main osc enable
   input wire         osc_sub_oe_n_o           // Sub osc enable
);
   wire       run = dev_state_i == `PSC_ST_RUN && !ext_reset_in_low_i;
   wire       sb  = dev_state_i == `PSC_ST_STANDBY && !ext_reset_in_low_i;
   wire       sel = standby_pin_level_sel_i;
   wire [1:0] f0  = pin_func_i[1:0];
   wire [1:0] f_top = pin_func_i[2*N-1 -: 2];
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_main_in_en: assert property (xtal_main_in_en_o)
      else $error("main osc input disabled");
   a_sub_in_en: assert property (xtal_sub_in_en_o)
      else $error("sub osc input disabled");
   a_reset_hiz: assert property (dev_state_i == `PSC_ST_POR [*3] |=>
      &pad_oe_n_o && osc_main_oe_n_o && osc_sub_oe_n_o)
      else $error("pad driven in reset");
   a_analog_off: assert property ((run && f0 == `PSC_FN_ANALOG)[*5] |=>
      analog_en_o[0] && pad_oe_n_o[0] && !core_in_o[0])
      else $error("analog pin wrong");
   a_hold_sel0: assert property ((run && f0 == `PSC_FN_GPIO)[*4] ##1
      (sb && !sel)[*6] |=> $stable(pad_out_o[0]) && $stable(pad_oe_n_o[0]))
      else $error("held pin changed");
   a_hiz_sel1: assert property ((run && f0 == `PSC_FN_GPIO)[*4] ##1
      (sb && sel)[*6] |=> pad_oe_n_o[0] && !core_in_o[0])
      else $error("pin not released");
   a_trace_drive: assert property ((run && f_top == `PSC_FN_TRACE)[*4] ##1
      (sb && sel)[*6] |=> !pad_oe_n_o[N-1])
      else $error("trace pin released");
   a_main_stop: assert property
      ((sb && standby_mode_i == `PSC_SB_SUB_TMR)[*4] |=>
      osc_main_oe_n_o && $stable(osc_sub_oe_n_o))
      else $error("main osc output wrong");
   a_sub_stop: assert property ((sb && standby_mode_i == `PSC_SB_STOP)[*4]
      |=> osc_sub_oe_n_o) else $error("sub osc output driven");
   a_func_frozen: assert property ((!run)[*3] |=> $stable(analog_en_o))
      else $error("selection taken outside run");
endmodule // psc_chk
bind psc_pin_state_controller psc_chk #(.N(N)) u_psc_chk (.ref_clk_i,
   .sys_rst_i, .dev_state_i, .standby_mode_i, .ext_reset_in_low_i,
   .standby_pin_level_sel_i, .pin_func_i, .pad_out_o, .pad_oe_n_o,
   .core_in_o, .analog_en_o, .xtal_main_in_en_o, .xtal_sub_in_en_o,
   .osc_main_oe_n_o, .osc_sub_oe_n_o);
`default_nettype wire

// ===== psc_pin_state_controller.v
// Contract
// R1 - Standby with select 0 keeps pin state
// R2 - Standby with select 1: drivers off, input low
// R3 - Held pin follows peripheral else latched port
// R4 - High impedance disables output driver
// R5 - Fixed input presents constant low internally
// R6 - Trace pins keep driving during standby
// R7 - Main oscillator input always input-enabled
// R8 - Main osc output Hi-Z only when stopped
// R9 - Sub osc output Hi-Z only in stop
// R10 - Sub oscillator input always input-enabled
// R11 - Disabled function selections ignored in that state
// R12 - Analog pins keep analog path, digital off
// R13 - State decoded from reset, pin, mode, select
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"

module psc_pin_state_controller #(
   parameter N = 16
) (
   input  wire                 ref_clk_i,          // 250 MHz clock
   input  wire                 sys_rst_i,          // Sync reset, high
   input  wire [2:0]           dev_state_i,        // Device state code
   input  wire [1:0]           standby_mode_i,     // Standby mode code
   input  wire                 ext_reset_in_low_i, // External reset pin
   input  wire                 standby_pin_level_sel_i, // Standby select
   input  wire [2*N-1:0]       pin_func_i,         // Function per pin
   input  wire [N-1:0]         port_out_i,         // Port output data
   input  wire [N-1:0]         port_oe_i,          // Port drive request
   input  wire [N-1:0]         periph_out_i,       // Peripheral data
   input  wire [N-1:0]         periph_oe_i,        // Peripheral drive
   input  wire [N-1:0]         pad_in_i,           // Pad input levels
   input  wire                 xtal_main_in_i,     // Main osc input pin
   input  wire                 xtal_sub_in_i,      // Sub osc input pin
   input  wire                 osc_main_out_i,     // Main osc drive level
   input  wire                 osc_sub_out_i,      // Sub osc drive level
   output reg  [N-1:0]         pad_out_o,          // Pad output levels
   output reg  [N-1:0]         pad_oe_n_o,         // Pad enable, low drive
   output reg  [N-1:0]         pad_pullup_o,       // Pull-up enable
   output reg  [N-1:0]         core_in_o,          // Internal input
   output reg  [N-1:0]         analog_en_o,        // Analog path enable
   output reg                  xtal_main_in_en_o,  // Main osc input enable
   output reg                  xtal_main_core_o,   // Main osc input level
   output reg                  xtal_sub_in_en_o,   // Sub osc input enable
   output reg                  xtal_sub_core_o,    // Sub osc input level
   output reg                  osc_main_out_o,     // Main osc out level
   output reg                  osc_main_oe_n_o,    // Main osc enable, low
   output reg                  osc_sub_out_o,      // Sub osc out level
   output reg                  osc_sub_oe_n_o      // Sub osc enable, low
);

   // Two-stage synchronisers for every asynchronous pin level.
   reg [N-1:0] pad_s1;
   reg [N-1:0] pad_s2;
   reg [3:0]   misc_s1;
   reg [3:0]   misc_s2;
   reg [1:0]   pad_state;
   reg [1:0]   next_pad_state;
   reg [2*N-1:0] func_lat;
   reg [N-1:0] hold_val;
   reg [N-1:0] hold_oe;
   reg         main_hold;
   reg         sub_hold;
   reg         main_stopped;
   reg         sub_stopped;
   integer     i;

   // The reset pin and the standby select come from outside the clock
   // domain, so the decode only ever sees their second-stage copies.
   // A pin glitch therefore never reaches the decode directly.
   // The device state code is already on this clock and is used raw,
   // which is why a state change acts two edges sooner than a pin.
   wire ext_low  = misc_s2[0];
   wire spl_sync = misc_s2[1];
   wire xm_sync  = misc_s2[2];
   wire xs_sync  = misc_s2[3];
   wire in_sb    = (dev_state_i == `PSC_ST_STANDBY);
   wire in_rst   = (dev_state_i == `PSC_ST_POR) ||
                   (dev_state_i == `PSC_ST_EXT_RST) ||
                   (dev_state_i == `PSC_ST_INT_RST) || ext_low;

   // Pin k owns the two function bits starting at twice its index.
   function [1:0] fn_of;
      input [2*N-1:0] v;
      input integer   k;
      begin
         fn_of = v[`PSC_FN_W*k +: `PSC_FN_W];
      end
   endfunction

   always @(posedge ref_clk_i) begin
      pad_s1  <= pad_in_i;
      pad_s2  <= pad_s1;
      misc_s1 <= {xtal_sub_in_i, xtal_main_in_i,
                  standby_pin_level_sel_i, ext_reset_in_low_i};
      misc_s2 <= misc_s1;
   end

   // Decoded every cycle; pad_state takes the result on the next clock edge.
   always @* begin
      if (in_rst)
         next_pad_state = `PSC_PS_RESET; // R13
      else if (in_sb && spl_sync)
         next_pad_state = `PSC_PS_HIZ; // R2
      else
         next_pad_state = `PSC_PS_HOLD; // R1
   end

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pad_state    <= `PSC_PS_RESET;
         func_lat     <= {2*N{1'b0}};
         hold_val     <= {N{1'b0}};
         hold_oe      <= {N{1'b0}};
         main_hold    <= 1'b0;
         sub_hold     <= 1'b0;
         main_stopped <= 1'b0;
         sub_stopped  <= 1'b0;
      end else begin
         pad_state <= next_pad_state; // R13
         // Function selection is only accepted in run mode; in reset
         // and standby the last accepted selection stays in force.
         if (!in_rst && !in_sb)
            func_lat <= pin_func_i; // R11
         // Port value latched while running, frozen on standby entry.
         if (!in_sb) begin
            hold_val  <= port_out_i; // R3
            hold_oe   <= port_oe_i; // R3
            main_hold <= osc_main_out_i;
            sub_hold  <= osc_sub_out_i;
         end
         // Oscillator stop flags are registered to line up with the
         // pad state register, so pad and oscillator pins release on
         // the same edge. Only the main timer keeps the main crystal
         // running; only stop mode halts the sub crystal.
         main_stopped <= in_sb &&
                         (standby_mode_i != `PSC_SB_MAIN_TMR); // R8
         sub_stopped  <= in_sb &&
                         (standby_mode_i == `PSC_SB_STOP); // R9
      end
   end

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pad_out_o         <= {N{1'b0}};
         pad_oe_n_o        <= {N{1'b1}};
         pad_pullup_o      <= {N{1'b0}};
         core_in_o         <= {N{1'b0}};
         analog_en_o       <= {N{1'b0}};
         xtal_main_in_en_o <= 1'b1;
         xtal_main_core_o  <= 1'b0;
         xtal_sub_in_en_o  <= 1'b1;
         xtal_sub_core_o   <= 1'b0;
         osc_main_out_o    <= 1'b0;
         osc_main_oe_n_o   <= 1'b1;
         osc_sub_out_o     <= 1'b0;
         osc_sub_oe_n_o    <= 1'b1;
      end else begin
         // Per-pin priority: analog, then reset, then standby release,
         // then peripheral, then the latched port value. Analog wins
         // because its digital path must stay off in every state.
         // The pull-up stays off: no pin of this block needs one, and
         // a pull fighting an analog source would corrupt its reading.
         for (i = 0; i < N; i = i + 1) begin
            pad_pullup_o[i] <= 1'b0;
            analog_en_o[i]  <= 1'b0;
            if (fn_of(func_lat, i) == `PSC_FN_ANALOG) begin
               pad_out_o[i]   <= 1'b0;
               pad_oe_n_o[i]  <= 1'b1; // R12
               core_in_o[i]   <= 1'b0; // R12
               analog_en_o[i] <= 1'b1; // R12
            end else if (pad_state == `PSC_PS_RESET) begin
               pad_out_o[i]  <= 1'b0;
               pad_oe_n_o[i] <= 1'b1; // R4
               core_in_o[i]  <= pad_s2[i];
            end else if (pad_state == `PSC_PS_HIZ &&
                         fn_of(func_lat, i) == `PSC_FN_TRACE) begin
               pad_out_o[i]  <= periph_out_i[i]; // R6
               pad_oe_n_o[i] <= 1'b0; // R6
               core_in_o[i]  <= 1'b0;
            end else if (pad_state == `PSC_PS_HIZ) begin
               pad_out_o[i]  <= 1'b0;
               pad_oe_n_o[i] <= 1'b1; // R4
               core_in_o[i]  <= 1'b0; // R5
            end else if (fn_of(func_lat, i) != `PSC_FN_GPIO) begin
               pad_out_o[i]  <= periph_out_i[i]; // R3
               pad_oe_n_o[i] <= ~periph_oe_i[i]; // R3
               core_in_o[i]  <= pad_s2[i];
            end else begin
               pad_out_o[i]  <= hold_val[i]; // R1
               pad_oe_n_o[i] <= ~hold_oe[i]; // R3
               core_in_o[i]  <= pad_s2[i];
            end
         end
         // Crystal inputs never lose their input path.
         xtal_main_in_en_o <= 1'b1; // R7
         xtal_main_core_o  <= xm_sync; // R7
         xtal_sub_in_en_o  <= 1'b1; // R10
         xtal_sub_core_o   <= xs_sync; // R10
         // In standby the oscillator pins replay the level captured on
         // entry, since their source may stop toggling at any time.
         // A stopped oscillator is released rather than held.
         if (pad_state == `PSC_PS_RESET || main_stopped) begin
            osc_main_out_o  <= 1'b0;
            osc_main_oe_n_o <= 1'b1; // R8
         end else begin
            osc_main_out_o  <= in_sb ? main_hold : osc_main_out_i;
            osc_main_oe_n_o <= 1'b0; // R8
         end
         if (pad_state == `PSC_PS_RESET || sub_stopped) begin
            osc_sub_out_o  <= 1'b0;
            osc_sub_oe_n_o <= 1'b1; // R9
         end else begin
            osc_sub_out_o  <= in_sb ? sub_hold : osc_sub_out_i;
            osc_sub_oe_n_o <= 1'b0; // R9
         end
      end
   end

endmodule // psc_pin_state_controller
`default_nettype wire

// ===== psc_pin_state_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module psc_pin_state_controller_tb;
   logic ref_clk_i = 0, sys_rst_i = 1, ext_reset_in_low_i = 0;
   logic standby_pin_level_sel_i = 0, osc_main_out_i = 1, osc_sub_out_i = 1;
   logic [2:0] dev_state_i = `PSC_ST_POR;
   logic [1:0] standby_mode_i = 2'h0;
   logic [7:0] pin_func_i = 8'h00;
   logic [3:0] port_out_i = 4'h0, port_oe_i = 4'h0;
   logic [3:0] periph_out_i = 4'h0, periph_oe_i = 4'h0;
   wire  [3:0] pad_in_i, pad_out_o, pad_oe_n_o, core_in_o, analog_en_o;
   wire        xtal, xtal_main_in_en_o, xtal_sub_in_en_o;
   wire        osc_main_oe_n_o, osc_sub_oe_n_o;
   wire  [3:0] pad_pullup_o;
   wire        osc_main_out_o, osc_sub_out_o;
   int         errors = 0, n_checks = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   psc_pin_state_controller #(.N(4)) u_psc_pin_state_controller (.ref_clk_i,
      .sys_rst_i, .dev_state_i, .standby_mode_i, .ext_reset_in_low_i,
      .standby_pin_level_sel_i, .pin_func_i, .port_out_i, .port_oe_i,
      .periph_out_i, .periph_oe_i, .pad_in_i, .xtal_main_in_i(xtal),
      .xtal_sub_in_i(xtal), .osc_main_out_i, .osc_sub_out_i, .pad_out_o,
      .pad_oe_n_o, .pad_pullup_o, .core_in_o, .analog_en_o,
      .xtal_main_in_en_o, .xtal_main_core_o(), .xtal_sub_in_en_o,
      .xtal_sub_core_o(), .osc_main_out_o, .osc_main_oe_n_o,
      .osc_sub_out_o, .osc_sub_oe_n_o);
   psc_board #(.N(4)) u_psc_board (.ref_clk_i, .drv_i(pad_out_o),
      .oe_n_i(pad_oe_n_o), .lvl_o(pad_in_i), .xtal_o(xtal));
   task automatic chk(input string nm, input logic [3:0] e, g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic go(input logic [2:0] st, input int n);
      dev_state_i = st;
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_reset;
      go(`PSC_ST_POR, 4);
      chk("oe_n", 4'hf, pad_oe_n_o);
      chk("pullup", 4'h0, pad_pullup_o);
      chk("osc", 4'hf, {osc_main_oe_n_o, osc_sub_oe_n_o,
         xtal_main_in_en_o, xtal_sub_in_en_o});
      $display("reset test done");
   endtask
   task automatic t_run_hold;
      pin_func_i = {`PSC_FN_TRACE, `PSC_FN_ANALOG, `PSC_FN_PERIPH, 2'h0};
      {port_out_i, port_oe_i, periph_out_i, periph_oe_i} = 16'h5fa7;
      go(`PSC_ST_RUN, 8);
      chk("oe_n", 4'hc, pad_oe_n_o);
      chk("out", 4'hb, pad_out_o & 4'hb);
      chk("analog", 4'h4, analog_en_o);
      chk("core", 4'h1, core_in_o & 4'h5);
      {port_out_i, periph_out_i, pin_func_i} = 16'h0000;
      go(`PSC_ST_STANDBY, 8);
      chk("held", 4'h1, pad_out_o & 4'hb);
      chk("frozen", 4'h4, analog_en_o);
      chk("osc", 4'h0, {2'h0, osc_main_oe_n_o, osc_sub_oe_n_o});
      chk("osc_out", 4'h3, {2'h0, osc_main_out_o, osc_sub_out_o});
      standby_pin_level_sel_i = 1'b1;
      go(`PSC_ST_STANDBY, 8);
      chk("hiz", 4'h7, pad_oe_n_o);
      chk("fixed", 4'h0, core_in_o & 4'h7);
      // Enter standby straight from run, setting the select at the same moment.
      pin_func_i = {`PSC_FN_TRACE, `PSC_FN_ANALOG, `PSC_FN_PERIPH, 2'h0};
      standby_pin_level_sel_i = 1'b0;
      go(`PSC_ST_RUN, 6);
      standby_pin_level_sel_i = 1'b1;
      go(`PSC_ST_STANDBY, 8);
      chk("hiz2", 4'h7, pad_oe_n_o);
      chk("fixed2", 4'h0, core_in_o & 4'h7);
      pin_func_i = 8'h00;
      $display("hold test done");
   endtask
   task automatic t_modes;
      standby_pin_level_sel_i = 1'b0;
      for (int m = 0; m < 4; m++) begin
         go(`PSC_ST_RUN, 6);
         standby_mode_i = m[1:0];
         go(`PSC_ST_STANDBY, 8);
         chk("osc", {2'h0, m != 0, m == 3},
            {2'h0, osc_main_oe_n_o, osc_sub_oe_n_o});
      end
      $display("mode test done");
   endtask
   task automatic t_ext;
      // The pin is synchronised, so it settles before the state moves.
      ext_reset_in_low_i = 1'b1;
      go(`PSC_ST_STANDBY, 4);
      pin_func_i = {4{`PSC_FN_ANALOG}};
      go(`PSC_ST_RUN, 8);
      chk("oe_n", 4'hf, pad_oe_n_o);
      chk("ignored", 4'h0, analog_en_o);
      ext_reset_in_low_i = 1'b0;
      go(`PSC_ST_RUN, 8);
      chk("taken", 4'hf, analog_en_o);
      $display("external reset test done");
   endtask
   initial begin
      repeat (5) @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      t_reset;
      t_run_hold;
      t_modes;
      t_ext;
      final_report;
   end
   initial begin
      #2000;
      errors++;
      final_report;
   end
endmodule // psc_pin_state_controller_tb
`default_nettype wire

// ===== psc_regs.vh
`ifndef PSC_REGS_VH
`define PSC_REGS_VH
// Device state codes presented on dev_state_i.
`define PSC_ST_POR        3'h0
`define PSC_ST_EXT_RST    3'h1
`define PSC_ST_INT_RST    3'h2
`define PSC_ST_RUN        3'h3
`define PSC_ST_STANDBY    3'h4
// Standby mode codes presented on standby_mode_i.
`define PSC_SB_MAIN_TMR   2'h0
`define PSC_SB_SUB_TMR    2'h1
`define PSC_SB_LCR_TMR    2'h2
`define PSC_SB_STOP       2'h3
// Pin function codes, two bits per pin on pin_func_i.
`define PSC_FN_GPIO       2'h0
`define PSC_FN_PERIPH     2'h1
`define PSC_FN_TRACE      2'h2
`define PSC_FN_ANALOG     2'h3
`define PSC_FN_W          2
// Pad state codes, internal.
`define PSC_PS_RESET      2'h0
`define PSC_PS_HOLD       2'h1
`define PSC_PS_HIZ        2'h2
`endif
